// [rtl/scsl_pkg.sv]
package scsl_pkg;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS    = 100;   // core clock period
  localparam int unsigned RESET_MIN_NS     = 400;   // least reset pulse
  localparam int unsigned RESET_CYCLES     = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  RESET_CNT_LAST   = 3'(RESET_CYCLES - 1);

  // ****************************************************
  // break detector counts (baud clocks)
  // ****************************************************
  localparam logic [7:0]  BRK_BREAK_PENDING_COUNT   = 8'h80;  // 128
  localparam logic [7:0]  BRK_SEEN_COUNT   = 8'hA0;  // 160

  // ****************************************************
  // baud selection
  // ****************************************************
  localparam logic [3:0]  RATE_SEL_EXT     = 4'h0;   // all switches closed
  localparam logic [3:0]  RATE_SEL_RESET   = 4'hF;   // pull-ups
  localparam int unsigned DIV_W            = 12;
  localparam logic [5:0]  SC_DIAG          = 6'h32; // card control select code (octal 32 read as label)

  // divisor table: core clock cycles per 16x tick
  function automatic logic [DIV_W-1:0] scsl_divisor(input logic [3:0] sel);
    logic [DIV_W-1:0] d;
    d = 12'h001;
    case (sel)
      4'h1: d = 12'h823;  // ~300 baud x16 at 10 MHz
      4'h2: d = 12'h411;
      4'h3: d = 12'h209;
      4'h4: d = 12'h104;
      4'h5: d = 12'h0AE;
      4'h6: d = 12'h082;
      4'h7: d = 12'h057;
      4'h8: d = 12'h041;
      4'h9: d = 12'h02B;
      4'hA: d = 12'h020;
      4'hB: d = 12'h016;
      4'hC: d = 12'h010;
      4'hD: d = 12'h00B;
      4'hE: d = 12'h008;
      4'hF: d = 12'h004;
      default: d = 12'h001;
    endcase
    return d;
  endfunction

endpackage

// [rtl/scsl_break_det.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// break detector on the shared baud tick
// ****************************************************
module scsl_break_det
  import scsl_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_baud_tick,   // one 16x baud clock
  input  wire logic i_rx_line,     // selected receive line
  output logic      o_pending,     // break pending
  output logic      o_break_evt    // break reported on return to mark
);
  logic [7:0] cnt_reg, cnt_next;   // spacing count
  logic       brk_reg, brk_next;   // jam-set break latch
  logic       evt_reg, evt_next;

  // next count, clears on marking
  always_comb begin
    cnt_next = cnt_reg;
    brk_next = brk_reg;
    evt_next = 1'b0;
    if (i_rx_line) begin
      cnt_next = 8'h00;
      if (brk_reg) begin
        evt_next = 1'b1;
        brk_next = 1'b0;
      end
    end else if (i_baud_tick) begin
      if (cnt_reg != 8'hFF) begin
        cnt_next = cnt_reg + 8'h01;
      end
      if (cnt_next == BRK_SEEN_COUNT) begin
        brk_next = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_reg <= 8'h00;
      brk_reg <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      brk_reg <= brk_next;
      evt_reg <= evt_next;
    end
  end

  // pending stays up through the whole spacing run, also past the break
  // count, because the break is only reported once the line marks again
  assign o_pending   = (cnt_reg >= BRK_BREAK_PENDING_COUNT);
  assign o_break_evt = evt_reg;
endmodule
`default_nettype wire

// [rtl/scsl_top.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// serial card support logic
// ****************************************************
module scsl_top
  import scsl_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,              // power-up reset
  input  wire logic       i_sys_reset,        // system reset pulse
  input  wire logic       i_card_ctl_wr,      // write strobe to card control code
  input  wire logic [7:0] i_card_ctl_data,    // data of that write
  input  wire logic [3:0] i_modem_lines,      // clear/data mode/call/ready
  input  wire logic [3:0] i_modem_ref,        // reference levels
  input  wire logic       i_modem_change_irq_enable,
  input  wire logic [3:0] i_rate_select,      // switch/hood lines, high when open
  input  wire logic       i_external_rate_clock,
  input  wire logic       i_secondary_send_line,   // control bit 2
  input  wire logic       i_terminal_ready_line,   // control bit 0
  input  wire logic       i_request_to_send,  // control register bit
  input  wire logic       i_parity_sense_sw,
  input  wire logic       i_stop_bit_select,
  input  wire logic       i_panel_mode,       // virtual panel configuration
  input  wire logic       i_special_char,     // last char special (high)
  input  wire logic       i_uart_txd,         // transceiver serial out
  input  wire logic       i_rx_data,          // line from terminal
  input  wire logic       i_dma_packed,       // packed byte transfer
  input  wire logic       i_set_input_dir,
  input  wire logic       i_set_output_dir,
  input  wire logic       i_other_irq,        // framing, overrun, parity
  output logic            o_baud_tick,        // shared transceiver clock enable
  output logic            o_uart_rxd,         // receive to transceiver
  output logic            o_uart_reset,       // stretched reset
  output logic            o_diag_mode,
  output logic            o_parity_sense,
  output logic            o_two_stop_bits,
  output logic            o_modem_change_flag,
  output logic            o_irq,
  output logic            o_panel_request,
  output logic            o_break_pending,
  output logic            o_special_char_flag_n,   // status bit 7
  output logic            o_send_data_a,
  output logic            o_send_data_b,
  output logic            o_send_data_u,
  output logic            o_rts_a,
  output logic            o_rts_b,
  output logic            o_rts_u,
  output logic            o_input_direction_latch,
  output logic            o_output_direction_latch,
  output logic            o_upper_byte_first
);

  // ****************************************************
  // reset stretch
  // ****************************************************
  // a reset request may last a single cycle, which is too short for the
  // transceiver; a latch holds the reset and a small counter times its
  // release, and a request during the hold starts the count over again
  typedef enum logic [1:0] {
    SCSL_RST_IDLE = 2'b01,
    SCSL_RST_HOLD = 2'b10
  } scsl_rst_t;

  scsl_rst_t  rst_st_reg, rst_st_next;
  logic [2:0] rst_cnt_reg, rst_cnt_next;
  logic       card_reset_req;

  // either of two sources starts a card reset
  assign card_reset_req = i_sys_reset ||
                          (i_card_ctl_wr);

  // latch set, count four cycles, then clear
  always_comb begin
    rst_st_next  = rst_st_reg;
    rst_cnt_next = rst_cnt_reg;
    case (rst_st_reg)
      SCSL_RST_IDLE: begin
        if (card_reset_req) begin
          rst_st_next  = SCSL_RST_HOLD;
          rst_cnt_next = 3'd0;
        end
      end
      SCSL_RST_HOLD: begin
        if (card_reset_req) begin
          rst_cnt_next = 3'd0;
        end else if (rst_cnt_reg == RESET_CNT_LAST) begin
          rst_st_next = SCSL_RST_IDLE;
        end else begin
          rst_cnt_next = rst_cnt_reg + 3'd1;
        end
      end
      default: begin
        rst_st_next  = SCSL_RST_IDLE;
        rst_cnt_next = 3'd0;
      end
    endcase
  end

  // power-up enters the hold state
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rst_st_reg  <= SCSL_RST_HOLD;
      rst_cnt_reg <= 3'd0;
    end else begin
      rst_st_reg  <= rst_st_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // the hold state is the latch itself, so the pulse comes straight off a flop
  assign o_uart_reset = (rst_st_reg == SCSL_RST_HOLD);

  // ****************************************************
  // diagnose latch
  // ****************************************************
  logic diag_reg, diag_next;

  // bit zero sets, zero write or system reset clears
  // a system reset outranks a write that falls in the same cycle
  always_comb begin
    diag_next = diag_reg;
    if (i_sys_reset) begin
      diag_next = 1'b0;
    end else if (i_card_ctl_wr) begin
      diag_next = i_card_ctl_data[0];
    end
  end

  // diagnose latch register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      diag_reg <= 1'b0;
    end else begin
      diag_reg <= diag_next;
    end
  end

  assign o_diag_mode = diag_reg;

  // ****************************************************
  // baud generator
  // ****************************************************
  logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;
  logic             ext_prev_reg, ext_prev_next;
  logic             tick_reg, tick_next;
  logic             ext_sel;

  // all four switches closed selects the external clock; any other code
  // picks a divisor of the core clock
  assign ext_sel = (i_rate_select == RATE_SEL_EXT);

  // the compare is greater-or-equal so that a higher rate select never
  // leaves the counter stranded above its new limit
  // divided core clock or external clock edges
  always_comb begin
    div_cnt_next  = div_cnt_reg;
    ext_prev_next = i_external_rate_clock;
    tick_next     = 1'b0;
    if (ext_sel) begin
      tick_next    = i_external_rate_clock && !ext_prev_reg;
      div_cnt_next = '0;
    end else if (div_cnt_reg >= scsl_divisor(i_rate_select) - 12'h001) begin
      div_cnt_next = '0;
      tick_next    = 1'b1;
    end else begin
      div_cnt_next = div_cnt_reg + 12'h001;
    end
  end

  // divider, edge detector and tick registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_cnt_reg  <= '0;
      // follow the pin through reset so that a clock already high at
      // release does not look like a rising edge
      ext_prev_reg <= ext_prev_next;
      tick_reg     <= 1'b0;
    end else begin
      div_cnt_reg  <= div_cnt_next;
      ext_prev_reg <= ext_prev_next;
      tick_reg     <= tick_next;
    end
  end

  // one tick feeds both directions and break logic
  assign o_baud_tick = tick_reg;

  // ****************************************************
  // diagnostic multiplexer
  // ****************************************************
  logic brk_line;

  // in diagnose mode the transmitter hears itself, the break detector
  // listens to the secondary send bit and software owns the parity sense

  assign o_uart_rxd     = diag_reg ? i_uart_txd : i_rx_data;
  assign brk_line       = diag_reg ? i_secondary_send_line : o_uart_rxd;
  assign o_parity_sense = diag_reg ? i_terminal_ready_line : i_parity_sense_sw;
  assign o_two_stop_bits = i_stop_bit_select;

  // ****************************************************
  // break detector
  // ****************************************************
  logic brk_evt;

  // a card reset also clears a half-counted break, so a stale spacing
  // count cannot survive into the next diagnose test

  scsl_break_det u_brk (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst || o_uart_reset),
    .i_baud_tick (tick_reg),
    .i_rx_line   (brk_line),
    .o_pending   (o_break_pending),
    .o_break_evt (brk_evt)
  );

  // ****************************************************
  // modem change and interrupt
  // ****************************************************
  logic mflag_reg, mflag_next;
  logic panel_reg, panel_next;
  logic irq_now;

  // the flag follows the compare every cycle: it drops as soon as the
  // lines agree with the reference again or the enable is cleared
  always_comb begin
    mflag_next = i_modem_change_irq_enable &&
                 (i_modem_lines != i_modem_ref);
    panel_next = brk_evt && i_panel_mode;
  end

  // flag and panel request registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mflag_reg <= 1'b0;
      panel_reg <= 1'b0;
    end else begin
      mflag_reg <= mflag_next;
      panel_reg <= panel_next;
    end
  end

  // break interrupts only outside panel mode; pending holds off
  assign irq_now = mflag_reg ||
                   (!o_break_pending && (i_other_irq || (brk_evt && !i_panel_mode)));
  assign o_modem_change_flag = mflag_reg;
  assign o_irq               = irq_now;
  assign o_panel_request     = panel_reg;

  // ****************************************************
  // direction latches
  // ****************************************************
  logic in_dir_reg, in_dir_next;
  logic out_dir_reg, out_dir_next;

  // interrupt wins over set: a request in the same cycle as an interrupt
  // must not reopen a transfer that the interrupt is shutting down
  always_comb begin
    in_dir_next  = in_dir_reg  || i_set_input_dir;
    out_dir_next = out_dir_reg || i_set_output_dir;
    if (irq_now) begin
      in_dir_next  = 1'b0;
      out_dir_next = 1'b0;
    end
  end

  // card reset also drops both directions
  always_ff @(posedge i_core_clk) begin
    if (i_rst || o_uart_reset) begin
      in_dir_reg  <= 1'b0;
      out_dir_reg <= 1'b0;
    end else begin
      in_dir_reg  <= in_dir_next;
      out_dir_reg <= out_dir_next;
    end
  end

  assign o_input_direction_latch  = in_dir_reg;
  assign o_output_direction_latch = out_dir_reg;

  // ****************************************************
  // terminal side lines and status
  // ****************************************************
  logic sd_reg;

  // diagnose mode holds line marking; the line is registered so that
  // switching modes never puts a glitch on the terminal wires
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sd_reg <= 1'b1;
    end else begin
      sd_reg <= diag_reg ? 1'b1 : i_uart_txd;
    end
  end

  // the b wire of each pair carries the inverse of the a wire
  assign o_send_data_a = sd_reg;
  assign o_send_data_b = !sd_reg;
  assign o_send_data_u = sd_reg;
  assign o_rts_a       = i_request_to_send;
  assign o_rts_b       = !i_request_to_send;
  assign o_rts_u       = i_request_to_send;
  assign o_special_char_flag_n = !i_special_char;
  assign o_upper_byte_first    = i_dma_packed;

endmodule
`default_nettype wire

// [verification/scsl_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// port checker for the support logic
// ****************************************************
module scsl_top_monitor (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_sys_reset,
  input wire logic       i_card_ctl_wr,
  input wire logic [7:0] i_card_ctl_data,
  input wire logic [3:0] i_modem_lines,
  input wire logic [3:0] i_modem_ref,
  input wire logic       i_modem_change_irq_enable,
  input wire logic       i_uart_txd,
  input wire logic       i_rx_data,
  input wire logic       i_request_to_send,
  input wire logic       o_uart_rxd,
  input wire logic       o_uart_reset,
  input wire logic       o_diag_mode,
  input wire logic       o_modem_change_flag,
  input wire logic       o_irq,
  input wire logic       o_send_data_a,
  input wire logic       o_send_data_b,
  input wire logic       o_send_data_u,
  input wire logic       o_rts_a,
  input wire logic       o_rts_b,
  input wire logic       o_rts_u,
  input wire logic       o_input_direction_latch,
  input wire logic       o_output_direction_latch
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // any reset request, then the stretched pulse
  sequence s_rst_req;
    i_sys_reset || i_card_ctl_wr;
  endsequence
  sequence s_stretch;
    o_uart_reset [*4];
  endsequence
  a_reset_stretch: assert property (s_rst_req |=> s_stretch)
    else $error("reset pulse too short");
  a_diag_write: assert property (i_card_ctl_wr && !i_sys_reset |=> o_diag_mode == $past(i_card_ctl_data[0]))
    else $error("diagnose latch not loaded");
  a_sys_clear: assert property (i_sys_reset && !i_card_ctl_wr |=> !o_diag_mode)
    else $error("diagnose latch not cleared");
  a_loop_back: assert property (o_uart_rxd == (o_diag_mode ? i_uart_txd : i_rx_data))
    else $error("receive path wrong");
  a_send_mark: assert property (o_diag_mode && $past(o_diag_mode) |-> o_send_data_a && o_send_data_u && !o_send_data_b)
    else $error("send data not marking");
  a_rts_pair: assert property (o_rts_a == i_request_to_send && o_rts_u == o_rts_a && o_rts_b == !o_rts_a)
    else $error("request to send wrong");
  a_modem_flag: assert property (i_modem_change_irq_enable && i_modem_lines != i_modem_ref |=> o_modem_change_flag)
    else $error("modem change missed");
  a_flag_irq: assert property (o_modem_change_flag |-> o_irq)
    else $error("modem change without request");
  a_irq_halts: assert property (o_irq |=> !o_input_direction_latch && !o_output_direction_latch)
    else $error("transfers not halted");
endmodule
bind scsl_top scsl_top_monitor mon (.*);
`default_nettype wire

// [verification/scsl_term_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// terminal side: 16x clock, receive line, modem lines
// ****************************************************
module scsl_term_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_run_clk,   // clock runs only when asked
  input  wire logic       i_space,     // hold the line spacing
  input  wire logic [3:0] i_lines,
  output logic            o_ext_clk,
  output logic [3:0]      o_modem,
  output logic            o_rx_line
);
  logic [2:0] div_reg;  // half period of 6 core cycles
  initial o_ext_clk = 1'b0;
  initial div_reg = 3'h0;
  // 833 kHz, under 16 x 56000; stands still when idle
  always @(posedge i_core_clk) begin
    if (i_run_clk) begin
      div_reg <= (div_reg == 3'h5) ? 3'h0 : div_reg + 3'h1;
      if (div_reg == 3'h5) o_ext_clk <= !o_ext_clk;
    end
  end
  assign o_rx_line = !i_space;  // marking when idle
  assign o_modem = i_lines;
endmodule
`default_nettype wire

// [verification/scsl_top_test.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************
// self-checking bench
// ****************************************************
module scsl_top_test;
  import scsl_pkg::*;
  logic i_core_clk, i_rst, i_sys_reset, i_card_ctl_wr, i_modem_change_irq_enable, i_external_rate_clock;
  logic i_secondary_send_line, i_terminal_ready_line, i_request_to_send, i_parity_sense_sw, i_stop_bit_select;
  logic i_panel_mode, i_special_char, i_uart_txd, i_rx_data, i_dma_packed, i_set_input_dir, i_set_output_dir;
  logic i_other_irq, o_baud_tick, o_uart_rxd, o_uart_reset, o_diag_mode, o_parity_sense, o_two_stop_bits;
  logic o_modem_change_flag, o_irq, o_panel_request, o_break_pending, o_special_char_flag_n, o_send_data_a;
  logic o_send_data_b, o_send_data_u, o_rts_a, o_rts_b, o_rts_u, o_input_direction_latch;
  logic o_output_direction_latch, o_upper_byte_first, run_clk, space, seen, break_pending, d;
  logic [7:0]  i_card_ctl_data;
  logic [3:0]  i_modem_lines, i_modem_ref, i_rate_select, lines;
  logic [31:0] lfsr;
  int          fail_count, total_checks, n, k, i, j;
  scsl_top uut (.*);
  scsl_term_model term (.i_core_clk(i_core_clk), .i_run_clk(run_clk), .i_space(space), .i_lines(lines),
    .o_ext_clk(i_external_rate_clock), .o_modem(i_modem_lines), .o_rx_line(i_rx_data));
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = !i_core_clk;
  end
  // next random word
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask
  // one-cycle request, then count the stretched reset
  task automatic ctl(input logic sys, input logic wr, input logic dat);
    i_sys_reset = sys;
    i_card_ctl_wr = wr;
    i_card_ctl_data = {7'h00, dat};
    cyc(1);
    i_sys_reset = 1'b0;
    i_card_ctl_wr = 1'b0;
    n = 0;
    for (k = 0; k < 8; k++) begin
      if (o_uart_reset === 1'b1) n++;
      cyc(1);
    end
  endtask
  // count shared ticks over 480 cycles
  task automatic ticks(input logic [3:0] sel, input logic run, input int lo, input int hi);
    i_rate_select = sel;
    run_clk = run;
    cyc(20);
    n = 0;
    for (k = 0; k < 480; k++) begin
      cyc(1);
      if (o_baud_tick === 1'b1) n++;
    end
    chk(12'(n >= lo && n <= hi), 12'h001);
  endtask
  // space the secondary send line, then mark and watch
  task automatic break_seen(input int len, input logic pm);
    i_panel_mode = pm;
    i_secondary_send_line = 1'b0;
    cyc(len);
    break_pending = o_break_pending;
    i_secondary_send_line = 1'b1;
    seen = 1'b0;
    for (k = 0; k < 20; k++) begin
      cyc(1);
      if ((pm ? o_panel_request : o_irq) === 1'b1) seen = 1'b1;
    end
    chk({break_pending, seen}, {1'(len >= 560), 1'(len >= 680)});
    ctl(1'b1, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #(100 * 90000);
    fail_count++;
    wrap_up();
  end
  initial begin
    {i_sys_reset, i_card_ctl_wr, i_modem_change_irq_enable, i_panel_mode, i_special_char, i_dma_packed} = 6'h00;
    {i_set_input_dir, i_set_output_dir, i_other_irq, i_parity_sense_sw, i_stop_bit_select, run_clk} = 6'h00;
    {i_secondary_send_line, i_terminal_ready_line, i_request_to_send, i_uart_txd, space} = 5'h1f;
    i_card_ctl_data = 8'h00;
    i_rate_select = 4'hf;
    lines = 4'h0;
    i_modem_ref = 4'h0;
    lfsr = 32'h30ab_158b;
    i_rst = 1'b1;
    cyc(10);
    i_rst = 1'b0;
    cyc(8);
    ctl(1'b0, 1'b1, 1'b1);
    chk({11'(n), o_diag_mode}, {11'h004, 1'b1});
    ctl(1'b0, 1'b1, 1'b0);
    chk({11'(n), o_diag_mode}, {11'h004, 1'b0});
    ctl(1'b0, 1'b1, 1'b1);
    ctl(1'b1, 1'b0, 1'b0);
    chk({11'(n), o_diag_mode}, {11'h004, 1'b0});
    $display("reset and diagnose latch done");
    ticks(4'hf, 1'b0, 119, 121);
    ticks(4'he, 1'b0, 59, 61);
    ticks(4'hc, 1'b0, 29, 31);
    ticks(4'h0, 1'b1, 39, 41);
    ticks(4'h0, 1'b0, 0, 0);
    i_rate_select = 4'hf;
    $display("rate selection done");
    ctl(1'b0, 1'b1, 1'b1);
    break_seen(400, 1'b1);
    break_seen(600, 1'b1);
    break_seen(700, 1'b1);
    break_seen(700, 1'b0);
    $display("break detect done");
    for (j = 0; j < 2; j++) begin
      ctl(1'b0, 1'b1, 1'(j));
      d = 1'(j);
      chk(12'(o_diag_mode), 12'(d));
      for (i = 0; i < 32; i++) begin
        lfsr = nxt(lfsr);
        {i_request_to_send, i_stop_bit_select, i_special_char, i_dma_packed} = lfsr[3:0];
        {i_terminal_ready_line, i_parity_sense_sw, i_uart_txd, space} = lfsr[7:4];
        cyc(2);
        chk({o_rts_a, o_rts_b, o_rts_u, o_two_stop_bits, o_special_char_flag_n, o_upper_byte_first},
            {i_request_to_send, !i_request_to_send, i_request_to_send, i_stop_bit_select,
             !i_special_char, i_dma_packed});
        chk({o_parity_sense, o_uart_rxd}, d ? {i_terminal_ready_line, i_uart_txd}
            : {i_parity_sense_sw, i_rx_data});
        chk({o_send_data_a, o_send_data_b, o_send_data_u},
            d ? 3'h5 : {i_uart_txd, !i_uart_txd, i_uart_txd});
      end
    end
    space = 1'b0;
    $display("diagnose paths done");
    i_modem_change_irq_enable = 1'b0;
    lines = 4'h5;
    cyc(2);
    i_set_input_dir = 1'b1;
    i_set_output_dir = 1'b1;
    cyc(1);
    i_set_input_dir = 1'b0;
    i_set_output_dir = 1'b0;
    cyc(1);
    chk({o_modem_change_flag, o_irq, o_input_direction_latch, o_output_direction_latch}, 12'h003);
    i_modem_change_irq_enable = 1'b1;
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      lines = lfsr[3:0];
      i_modem_ref = lines ^ (4'h1 << i);
      cyc(2);
      chk({o_modem_change_flag, o_irq, o_input_direction_latch, o_output_direction_latch}, 12'h00c);
    end
    // any other request also halts transfers, even with a set pending
    i_modem_change_irq_enable = 1'b0;
    i_other_irq = 1'b1;
    i_set_input_dir = 1'b1;
    cyc(2);
    chk({o_modem_change_flag, o_irq, o_input_direction_latch}, 12'h002);
    i_other_irq = 1'b0;
    i_set_input_dir = 1'b0;
    $display("modem change done");
    wrap_up();
  end
endmodule
`default_nettype wire
